// ===== shared/ddwc_defs.svh
// Register offsets, field positions, reset values and timing counts of the DAC control block.
`ifndef DDWC_DEFS_SVH
`define DDWC_DEFS_SVH
// Register byte offsets on the register bus.
`define DDWC_OFS_CTRL    8'h00
`define DDWC_OFS_SWTRIG  8'h04
`define DDWC_OFS_DR12    8'h08
`define DDWC_OFS_DL12    8'h0C
`define DDWC_OFS_DR8     8'h10
`define DDWC_OFS_OUT     8'h14
`define DDWC_OFS_STAT    8'h18
// Control word layout; channel 2 sits one stride above channel 1.
`define DDWC_CH_STRIDE   16
`define DDWC_TEN_BIT     0
`define DDWC_TSEL_LSB    1
`define DDWC_WAVE_LSB    4
`define DDWC_MASK_LSB    6
`define DDWC_DMA_BIT     10
`define DDWC_CTRL_MASK   32'h07FF07FF
// Trigger source codes.
`define DDWC_TSEL_EXT    3'h6
`define DDWC_TSEL_SW     3'h7
// Mask field value from which all twelve bits are used.
`define DDWC_MASK_FULL   4'hB
// Noise register reset value and feedback taps.
`define DDWC_NOISE_SHIFT_REG_INIT   12'hAAA
`define DDWC_NOISE_SHIFT_REG_TAPS   12'h829
// Transfer latency in bus clock cycles for hardware and software triggers.
`define DDWC_HW_CYCLES   3
`define DDWC_SW_CYCLES   1
// AXI response codes.
`define DDWC_RESP_OKAY   2'h0
`define DDWC_RESP_SLVERR 2'h2
`endif

// ===== shared/ddwc_pkg.sv
// Types shared by the DAC control block.
package ddwc_pkg;
   // Twelve-bit converter code.
   typedef logic [11:0] ddwc_code_t;
   // Wave generator selection; both codes with the upper bit set pick the triangle.
   typedef enum logic [1:0] {
      DDWC_WAVE_OFF     = 2'h0,
      DDWC_WAVE_NOISE   = 2'h1,
      DDWC_WAVE_TRI     = 2'h2,
      DDWC_WAVE_TRI_ALT = 2'h3
   } ddwc_wave_e;
endpackage : ddwc_pkg

// ===== shared/ddwc_chan_if.sv
// Signals that join the register file, one channel datapath and its wave generator.
`timescale 1ns/1ps
interface ddwc_chan_if;
   import ddwc_pkg::*;
   logic       trig_en;   // Trigger enable of the channel.
   ddwc_wave_e wave_sel;  // Wave generator selection.
   logic [3:0] mask_sel;  // Noise mask or triangle amplitude.
   logic       dma_en;    // DMA request enable.
   ddwc_code_t held;      // Held data word.
   logic       held_wr;   // Pulse in the cycle after the held word changed.
   logic       hw_fire;   // Hardware trigger event.
   logic       sw_fire;   // Software trigger event.
   logic       dma_ack;   // DMA controller services the request.
   logic       load;      // Output register loads in this cycle.
   ddwc_code_t wave_val;  // Value added to the held word.
   ddwc_code_t out_code;  // Output register.
   logic       dma_req;   // Pending DMA request.
   modport ctl  (output trig_en, wave_sel, mask_sel, dma_en, held, held_wr,
                 output hw_fire, sw_fire, dma_ack,
                 input  load, wave_val, out_code, dma_req);
   modport chan (input  trig_en, dma_en, held, held_wr, hw_fire, sw_fire, dma_ack, wave_val,
                 output load, out_code, dma_req);
   modport wave (input  trig_en, wave_sel, mask_sel, load,
                 output wave_val);
endinterface : ddwc_chan_if

// ===== hw/ddwc_wave.sv
// Noise and triangle generator of one DAC channel.
`timescale 1ns/1ps
`include "ddwc_defs.svh"
module ddwc_wave
   import ddwc_pkg::*;
(
   // Clock and reset.
   input  wire logic  ref_clk,
   input  wire logic  arst_n,
   // Channel link.
   ddwc_chan_if.wave  cif
);
   ddwc_code_t  noise_shift_reg_r, noise_shift_reg_nxt;  // Noise shift register.
   ddwc_code_t  tri_r, tri_nxt;    // Triangle counter.
   logic        up_r, up_nxt;      // Triangle counts upward when set.
   ddwc_code_t  mask;              // Unmasked bits, also the triangle peak.
   logic [12:0] span;              // Wide form of the mask before trimming.
   logic        step;              // A trigger advances the generator.
   logic        noise;             // Noise mode selected.
   logic        tri_on;            // Triangle mode selected.

   // Next values of the generators; only a triggered load moves them.
   always_comb begin
      span     = (13'h0002 << cif.mask_sel) - 13'h0001;
      mask     = (cif.mask_sel >= `DDWC_MASK_FULL) ? 12'hFFF : span[11:0];
      step     = cif.load & cif.trig_en;
      noise    = (cif.wave_sel == DDWC_WAVE_NOISE);
      tri_on   = cif.wave_sel[1];
      noise_shift_reg_nxt = noise_shift_reg_r;
      tri_nxt  = tri_r;
      up_nxt   = up_r;
      if (step && noise) begin
         // Shift left with the parity of the tap bits fed back in.
         noise_shift_reg_nxt = {noise_shift_reg_r[10:0], ^(noise_shift_reg_r & `DDWC_NOISE_SHIFT_REG_TAPS)};
      end
      if (step && tri_on) begin
         // Count up to the peak, then down to zero, and again.
         if (up_r && tri_r >= mask) begin
            up_nxt  = 1'b0;
            tri_nxt = tri_r - 12'h001;
         end else if (!up_r && tri_r == 12'h000) begin
            up_nxt  = 1'b1;
            tri_nxt = tri_r + 12'h001;
         end else begin
            tri_nxt = up_r ? tri_r + 12'h001 : tri_r - 12'h001;
         end
      end
      // Without a trigger enable nothing is added to the held word.
      if (!cif.trig_en) cif.wave_val = 12'h000;
      else if (noise) cif.wave_val = noise_shift_reg_r & mask;
      else if (tri_on) cif.wave_val = tri_r;
      else cif.wave_val = 12'h000;
   end

   // Generator registers; each channel owns its own noise register.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         noise_shift_reg_r <= `DDWC_NOISE_SHIFT_REG_INIT;
         tri_r  <= 12'h000;
         up_r   <= 1'b1;
      end else begin
         noise_shift_reg_r <= noise_shift_reg_nxt;
         tri_r  <= tri_nxt;
         up_r   <= up_nxt;
      end
   end

   chk_noise_shift_reg_moves: assert property (@(posedge ref_clk) disable iff (!arst_n)
      step && noise |=> noise_shift_reg_r != $past(noise_shift_reg_r)) else $error("noise register did not advance");
   chk_tri_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !step |=> $stable(tri_r)) else $error("triangle moved without a trigger");
   chk_tri_turn: assert property (@(posedge ref_clk) disable iff (!arst_n)
      step && tri_on && !up_r && tri_r == 12'h000 |=> up_r && tri_r == 12'h001)
      else $error("triangle did not turn at zero");
endmodule : ddwc_wave

// ===== hw/ddwc_chan.sv
// Trigger delay, output register and DMA request of one DAC channel.
`timescale 1ns/1ps
module ddwc_chan
   import ddwc_pkg::*;
(
   // Clock and reset.
   input  wire logic  ref_clk,
   input  wire logic  arst_n,
   // Channel link.
   ddwc_chan_if.chan  cif
);
   logic [1:0]  pipe_r, pipe_nxt;  // Hardware trigger delay stages.
   ddwc_code_t  out_r, out_nxt;    // Output register.
   logic        dma_r, dma_nxt;    // Pending DMA request.
   logic [12:0] sum;               // Held word plus wave value with carry.

   // Load sources: delayed hardware trigger, software trigger, or an untriggered write.
   assign cif.load = pipe_r[1] | cif.sw_fire | (cif.held_wr & ~cif.trig_en);
   assign cif.out_code = out_r;
   assign cif.dma_req  = dma_r;

   // Next values of delay line, output register and request.
   always_comb begin
      pipe_nxt = {pipe_r[0], cif.hw_fire};
      sum      = {1'b0, cif.held} + {1'b0, cif.wave_val};
      out_nxt  = cif.load ? sum[11:0] : out_r;
      dma_nxt  = dma_r;
      if (cif.dma_ack) dma_nxt = 1'b0;
      // A trigger while a request waits merges into it; setting wins over the clear.
      if (cif.hw_fire && cif.dma_en) dma_nxt = 1'b1;
   end

   // Channel registers.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pipe_r <= 2'h0;
         out_r  <= 12'h000;
         dma_r  <= 1'b0;
      end else begin
         pipe_r <= pipe_nxt;
         out_r  <= out_nxt;
         dma_r  <= dma_nxt;
      end
   end

   chk_sum_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
      cif.load |=> out_r == $past(sum[11:0])) else $error("output missed held plus wave");
   chk_out_steady: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !cif.load |=> $stable(out_r)) else $error("output changed without a load");
endmodule : ddwc_chan

// ===== hw/ddwc_top.sv
// Two-channel DAC control: register file, trigger selection, channel datapaths.
// Contract
// - DMA enabled: hardware trigger raises request, software not
// - Requests never queue; extra trigger dropped silently
// - Wave select 01 enables noise generator
// - Mask field chooses unmasked noise register bits
// - Noise: masked value plus held word, carry dropped
// - Noise register resets to 0xAAA
// - Noise register advances with the delayed load
// - Wave select 10 enables triangle; field sets peak
// - Triangle: counter plus held word, overflow dropped
// - Triangle updates on load, up to peak, down
// - Triangle advances only with trigger enable set
// - Three dual data registers load both channels
// - Independent triggers: each channel loads three cycles later
// - Separate noise register per channel, own advance
// - Output code maps linearly, 4095 full scale
// - Idle channel still accepts its own setup
// - Hardware trigger transfers held word in three cycles
// - Software trigger transfers held word in one cycle
// - Eight-bit write lands in held bits 11 to 4
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ddwc_defs.svh"
module ddwc_top
   import ddwc_pkg::*;
(
   // Clock and reset.
   input  wire logic         ref_clk,
   input  wire logic         arst_n,
   // AXI4-Lite write address and data.
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   // Trigger sources: timer events on this clock and the external line pin.
   input  wire logic [5:0]   timer_trig,
   input  wire logic         ext_trig_line,
   // DMA handshake, one pair per channel.
   output logic [1:0]        dma_req,
   input  wire logic [1:0]   dma_ack,
   // Output codes towards the converters.
   output logic [11:0]       output_code_ch1,
   output logic [11:0]       output_code_ch2
);
   logic [31:0]            ctrl_r, ctrl_nxt;    // Control word of both channels.
   logic [1:0][11:0]       held_r, held_nxt;    // Held data words.
   logic [1:0]             hwr_r, hwr_nxt;      // Held word changed last cycle.
   logic [1:0]             sw_r, sw_nxt;        // Software trigger pulses.
   logic                   bvalid_r, bvalid_nxt; // Write response pending.
   logic [1:0]             bresp_r, bresp_nxt;  // Write response code.
   logic                   rvalid_r, rvalid_nxt; // Read data pending.
   logic [1:0]             rresp_r, rresp_nxt;  // Read response code.
   logic [31:0]            rdata_r, rdata_nxt;  // Read data.
   logic [31:0]            wmask;               // Byte strobes spread to bits.
   logic                   wr_go;               // Write address and data taken.
   logic                   rd_go;               // Read address taken.
   logic [2:0]             ext_sync_r;          // Pin synchroniser and edge stage.
   logic                   ext_rise;            // Rising edge of the external line.
   logic [1:0][11:0]       out_code;            // Output registers of the channels.

   // One channel link per channel.
   ddwc_chan_if cif [2] ();

   // Write is taken when address and data are both offered and no response waits.
   assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   // Read is taken whenever no read data waits.
   assign rd_go         = s_axi_arvalid & ~rvalid_r;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;
   assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   // Edge of the external line after the second synchroniser stage.
   assign ext_rise = ext_sync_r[1] & ~ext_sync_r[2];

   // Register writes and write response.
   always_comb begin
      ctrl_nxt   = ctrl_r;
      held_nxt   = held_r;
      hwr_nxt    = 2'h0;
      sw_nxt     = 2'h0;
      bvalid_nxt = bvalid_r & ~s_axi_bready;
      bresp_nxt  = bresp_r;
      if (wr_go) begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = `DDWC_RESP_OKAY;
         unique case (s_axi_awaddr)
            // Control fields honour byte strobes; reserved bits stay zero.
            `DDWC_OFS_CTRL: begin
               ctrl_nxt = ((ctrl_r & ~wmask) | (s_axi_wdata & wmask)) & `DDWC_CTRL_MASK;
            end
            // Software trigger bits act once and are not stored.
            `DDWC_OFS_SWTRIG: begin
               sw_nxt = s_axi_wdata[1:0];
            end
            // Dual registers: one write loads both held words.
            `DDWC_OFS_DR12: begin
               held_nxt = {s_axi_wdata[27:16], s_axi_wdata[11:0]};
               hwr_nxt  = 2'h3;
            end
            `DDWC_OFS_DL12: begin
               held_nxt = {s_axi_wdata[31:20], s_axi_wdata[15:4]};
               hwr_nxt  = 2'h3;
            end
            `DDWC_OFS_DR8: begin
               // Eight-bit data fills the upper bits of each held word.
               held_nxt = {s_axi_wdata[15:8], 4'h0, s_axi_wdata[7:0], 4'h0};
               hwr_nxt  = 2'h3;
            end
            // Read-only words accept the write and ignore it.
            `DDWC_OFS_OUT, `DDWC_OFS_STAT: begin
               bresp_nxt = `DDWC_RESP_OKAY;
            end
            // Unmapped address.
            default: begin
               bresp_nxt = `DDWC_RESP_SLVERR;
            end
         endcase
      end
   end

   // Read data and read response.
   always_comb begin
      rvalid_nxt = rvalid_r & ~s_axi_rready;
      rresp_nxt  = rresp_r;
      rdata_nxt  = rdata_r;
      if (rd_go) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = `DDWC_RESP_OKAY;
         unique case (s_axi_araddr)
            `DDWC_OFS_CTRL:   rdata_nxt = ctrl_r;
            `DDWC_OFS_SWTRIG: rdata_nxt = 32'h00000000;
            `DDWC_OFS_DR12:   rdata_nxt = {4'h0, held_r[1], 4'h0, held_r[0]};
            `DDWC_OFS_DL12:   rdata_nxt = {held_r[1], 4'h0, held_r[0], 4'h0};
            `DDWC_OFS_DR8:    rdata_nxt = {16'h0000, held_r[1][11:4], held_r[0][11:4]};
            // Live output codes and pending requests show the block's own state.
            `DDWC_OFS_OUT:    rdata_nxt = {4'h0, out_code[1], 4'h0, out_code[0]};
            `DDWC_OFS_STAT:   rdata_nxt = {30'h00000000, dma_req};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = `DDWC_RESP_SLVERR;
            end
         endcase
      end
   end

   // Register file, bus response and pin synchroniser.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r     <= 32'h00000000;
         held_r     <= '0;
         hwr_r      <= 2'h0;
         sw_r       <= 2'h0;
         bvalid_r   <= 1'b0;
         bresp_r    <= `DDWC_RESP_OKAY;
         rvalid_r   <= 1'b0;
         rresp_r    <= `DDWC_RESP_OKAY;
         rdata_r    <= 32'h00000000;
         ext_sync_r <= 3'h0;
      end else begin
         ctrl_r     <= ctrl_nxt;
         held_r     <= held_nxt;
         hwr_r      <= hwr_nxt;
         sw_r       <= sw_nxt;
         bvalid_r   <= bvalid_nxt;
         bresp_r    <= bresp_nxt;
         rvalid_r   <= rvalid_nxt;
         rresp_r    <= rresp_nxt;
         rdata_r    <= rdata_nxt;
         ext_sync_r <= {ext_sync_r[1:0], ext_trig_line};
      end
   end

   assign output_code_ch1 = out_code[0];
   assign output_code_ch2 = out_code[1];

   // Each channel decodes its own fields and fires independently of the other.
   for (genvar i = 0; i < 2; i++) begin : g_chan
      localparam int B = i * `DDWC_CH_STRIDE;
      logic [2:0] tsel;  // Trigger source selection.
      logic       hw_ev; // Selected hardware event.

      assign tsel = ctrl_r[B + `DDWC_TSEL_LSB +: 3];
      // Timer events, external edge, or nothing for the software code.
      always_comb begin
         if (tsel == `DDWC_TSEL_EXT) hw_ev = ext_rise;
         else if (tsel == `DDWC_TSEL_SW) hw_ev = 1'b0;
         else hw_ev = timer_trig[tsel];
      end

      assign cif[i].trig_en  = ctrl_r[B + `DDWC_TEN_BIT];
      assign cif[i].wave_sel = ddwc_wave_e'(ctrl_r[B + `DDWC_WAVE_LSB +: 2]);
      assign cif[i].mask_sel = ctrl_r[B + `DDWC_MASK_LSB +: 4];
      assign cif[i].dma_en   = ctrl_r[B + `DDWC_DMA_BIT];
      assign cif[i].held     = held_r[i];
      assign cif[i].held_wr  = hwr_r[i];
      assign cif[i].hw_fire  = cif[i].trig_en & hw_ev;
      // Software trigger loads in the cycle after the write.
      assign cif[i].sw_fire  = sw_r[i] & cif[i].trig_en & (tsel == `DDWC_TSEL_SW);
      assign cif[i].dma_ack  = dma_ack[i];
      assign dma_req[i]      = cif[i].dma_req;
      assign out_code[i]     = cif[i].out_code;

      ddwc_chan u_chan (
         .ref_clk (ref_clk),
         .arst_n  (arst_n),
         .cif     (cif[i])
      );

      ddwc_wave u_wave (
         .ref_clk (ref_clk),
         .arst_n  (arst_n),
         .cif     (cif[i])
      );

      chk_hw_three: assert property (@(posedge ref_clk) disable iff (!arst_n)
         cif[i].hw_fire |-> ##2 cif[i].load) else $error("hardware transfer not in three");
      chk_sw_one: assert property (@(posedge ref_clk) disable iff (!arst_n)
         cif[i].sw_fire |=> out_code[i] == 12'($past(cif[i].held) + $past(cif[i].wave_val)))
         else $error("software transfer not in one");
      chk_dma_raise: assert property (@(posedge ref_clk) disable iff (!arst_n)
         cif[i].hw_fire && cif[i].dma_en |=> dma_req[i]) else $error("no DMA request");
      chk_dma_no_sw: assert property (@(posedge ref_clk) disable iff (!arst_n)
         cif[i].sw_fire && !cif[i].hw_fire && !dma_req[i] |=> !dma_req[i])
         else $error("software trigger raised DMA");
      chk_dma_no_queue: assert property (@(posedge ref_clk) disable iff (!arst_n)
         dma_req[i] && dma_ack[i] && !cif[i].hw_fire |=> !dma_req[i])
         else $error("a dropped trigger was queued");
      chk_untrig_copy: assert property (@(posedge ref_clk) disable iff (!arst_n)
         hwr_r[i] && !cif[i].trig_en |=> out_code[i] == $past(held_r[i]))
         else $error("untriggered copy missed");

      cov_noise_hw: cover property (@(posedge ref_clk) disable iff (!arst_n)
         cif[i].hw_fire && cif[i].wave_sel == DDWC_WAVE_NOISE ##2 cif[i].load);
      cov_tri_hw: cover property (@(posedge ref_clk) disable iff (!arst_n)
         cif[i].hw_fire && cif[i].wave_sel[1] ##2 cif[i].load);
      cov_dma_drop: cover property (@(posedge ref_clk) disable iff (!arst_n)
         dma_req[i] && cif[i].hw_fire && cif[i].dma_en);
   end

   chk_dual_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_go && s_axi_awaddr == `DDWC_OFS_DR12 |=> hwr_r == 2'h3)
      else $error("dual write did not load both");
   cov_dual_sw: cover property (@(posedge ref_clk) disable iff (!arst_n)
      cif[0].sw_fire && cif[1].sw_fire);
endmodule : ddwc_top

// ===== tb/ddwc_dma_model.sv
// DMA controller model that services each channel request after a set lag.
`timescale 1ns/1ps
module ddwc_dma_model (
   // Clock and reset.
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   // Requests in, acknowledges out, lag setting and service count.
   input  wire logic [1:0] dma_req,
   input  wire logic [3:0] lag,
   output logic      [1:0] dma_ack,
   output logic      [7:0] ack_cnt
);
   logic [3:0] wait_r [2];  // Cycles each request has waited.
   // Acknowledge for one cycle once the lag has run out, then count it.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dma_ack <= 2'h0;
         ack_cnt <= 8'h0;
         wait_r  <= '{4'h0, 4'h0};
      end else begin
         ack_cnt <= ack_cnt + 8'(dma_ack[0]) + 8'(dma_ack[1]);
         for (int c = 0; c < 2; c++) begin
            dma_ack[c] <= !dma_ack[c] && dma_req[c] && (wait_r[c] >= lag);
            if (!dma_ack[c] && dma_req[c]) begin
               wait_r[c]  <= (wait_r[c] >= lag) ? 4'h0 : wait_r[c] + 4'h1;
            end
         end
      end
   end
endmodule : ddwc_dma_model

// ===== tb/dual_dac_wave_dma_control_tb.sv
// Self-checking bench of the two-channel DAC control block.
`timescale 1ns/1ps
`include "ddwc_defs.svh"
module dual_dac_wave_dma_control_tb;
   logic        ref_clk, arst_n, ext_trig_line, up;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, ack_cnt, n;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
   logic [3:0]  s_axi_wstrb, lag, m [2];
   logic [1:0]  s_axi_bresp, s_axi_rresp, dma_req, dma_ack, rsp;
   logic [5:0]  timer_trig;
   logic [11:0] output_code_ch1, output_code_ch2, tv, pk, h [2], l [2], cur [2];
   int          miscompares, compares, cyc, c;
   ddwc_top       i_ddwc_top (.*);
   ddwc_dma_model i_ddwc_dma_model (.*);
   always #2.5 ref_clk = ~ref_clk;
   // Cut a hang short.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   function automatic logic [11:0] mk(input logic [3:0] k);
      return (k >= `DDWC_MASK_FULL) ? 12'hFFF : 12'((13'h2 << k) - 13'h1);
   endfunction : mk
   function automatic logic [11:0] lf(input logic [11:0] x);
      return {x[10:0], x[11] ^ x[5] ^ x[3] ^ x[0]};
   endfunction : lf
   function automatic logic [15:0] cw(input logic t, input logic [2:0] s, input logic [1:0] w,
                                      input logic [3:0] k, input logic dm);
      return {5'h0, dm, k, w, s, t};
   endfunction : cw
   function automatic logic [11:0] ex(input int i, input logic [31:0] x);
      return (i == 0) ? x[11:0] : (i == 1) ? x[15:4] : {x[7:0], 4'h0};
   endfunction : ex
   function automatic logic [31:0] oc(input int k);
      return 32'(k ? output_code_ch2 : output_code_ch1);
   endfunction : oc
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One register bus transfer; write when w is high.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata  <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      do @(negedge ref_clk); while (!(w ? s_axi_awready : s_axi_arready));
      @(posedge ref_clk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
      do @(negedge ref_clk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
      rd  = s_axi_rdata;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      @(posedge ref_clk);
      {s_axi_bready, s_axi_rready} <= 2'h0;
   endtask : bus
   // Timer trigger on channel k in noise mode; checks the exact load cycle.
   task automatic nz(input int k);
      @(posedge ref_clk) timer_trig <= 6'h1 << k;
      @(posedge ref_clk) timer_trig <= 6'h0;
      repeat (2) @(negedge ref_clk);
      chk(oc(k), 32'(cur[k]));
      @(negedge ref_clk);
      cur[k] = h[k] + (l[k] & mk(m[k]));
      chk(oc(k), 32'(cur[k]));
      chk(oc(1 - k), 32'(cur[1 - k]));
      l[k] = lf(l[k]);
   endtask : nz
   task automatic end_of_test();
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      {ref_clk, arst_n, ext_trig_line, s_axi_awvalid, s_axi_wvalid} = 5'h0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, timer_trig, lag} = 13'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      void'($urandom(32'hDF50533C));
      repeat (16) @(posedge ref_clk);
      chk(oc(0), 32'h0);
      arst_n <= 1'b1;
      // Untriggered copies through the three dual data layouts.
      for (int i = 0; i < 3; i++) begin
         d = $urandom;
         bus(1'b1, 8'(8 + 4 * i), d);
         repeat (2) @(negedge ref_clk);
         chk(oc(0), 32'(ex(i, d)));
         chk(oc(1), 32'(ex(i, (i == 2) ? d >> 8 : d >> 16)));
      end
      // Unmapped offset answers with an error and reads zero.
      bus(1'b1, 8'h1C, 32'hFFFFFFFF);
      chk(32'(rsp), 32'(`DDWC_RESP_SLVERR));
      bus(1'b0, 8'h1C, 32'h0);
      chk({rd[29:0], rsp}, 32'(`DDWC_RESP_SLVERR));
      // Noise on both channels from own timers, DMA on channel one only.
      h = '{12'($urandom), 12'($urandom)};
      m = '{4'($urandom), 4'($urandom)};
      bus(1'b1, `DDWC_OFS_DR12, {4'h0, h[1], 4'h0, h[0]});
      cur = h;
      l = '{`DDWC_NOISE_SHIFT_REG_INIT, `DDWC_NOISE_SHIFT_REG_INIT};
      d = {cw(1, 3'h1, 2'h1, m[1], 0), cw(1, 3'h0, 2'h1, m[0], 1)};
      bus(1'b1, `DDWC_OFS_CTRL, d);
      lag <= 4'($urandom % 4);
      for (int k = 0; k < 8; k++) begin
         c = $urandom % 2;
         nz(c);
      end
      // A second trigger before service is dropped, not queued.
      lag <= 4'hC;
      repeat (20) @(posedge ref_clk);
      n = ack_cnt;
      nz(0);
      chk(32'(dma_req), 32'h1);
      nz(0);
      repeat (30) @(posedge ref_clk);
      chk(32'(ack_cnt), 32'(n + 8'h1));
      // Triangle by software trigger on channel two; channel one untriggered.
      // Both channels are switched off before the amplitude field changes.
      bus(1'b1, `DDWC_OFS_CTRL, 32'h0);
      m[1] = 4'($urandom % 3);
      pk = mk(m[1]);
      d = {cw(1, 3'h7, 2'h2, m[1], 1), cw(0, 3'h0, 2'h2, m[0], 0)};
      bus(1'b1, `DDWC_OFS_CTRL, d);
      bus(1'b0, `DDWC_OFS_CTRL, 32'h0);
      chk(rd, d);
      h = '{12'($urandom), 12'($urandom)};
      bus(1'b1, `DDWC_OFS_DR12, {4'h0, h[1], 4'h0, h[0]});
      tv = 12'h0;
      up = 1'b1;
      for (int k = 0; k < 10; k++) begin
         bus(1'b1, `DDWC_OFS_SWTRIG, 32'h2);
         repeat (2) @(negedge ref_clk);
         chk(oc(1), 32'(h[1] + tv));
         chk(32'(dma_req), 32'h0);
         up = up ? (tv != pk) : (tv == 12'h0);
         tv = up ? tv + 12'h1 : tv - 12'h1;
      end
      chk(oc(0), 32'(h[0]));
      // External line edge on channel one: two sync stages and an edge stage come first.
      d = {cw(1, 3'h7, 2'h2, m[1], 1), cw(1, 3'h6, 2'h0, m[0], 0)};
      bus(1'b1, `DDWC_OFS_CTRL, d);
      cur[0] = h[0];
      h = '{12'($urandom), 12'($urandom)};
      bus(1'b1, `DDWC_OFS_DR12, {4'h0, h[1], 4'h0, h[0]});
      @(posedge ref_clk) ext_trig_line <= 1'b1;
      repeat (5) @(negedge ref_clk);
      chk(oc(0), 32'(cur[0]));
      @(negedge ref_clk);
      chk(oc(0), 32'(h[0]));
      end_of_test();
   end
endmodule : dual_dac_wave_dma_control_tb
